// *** verilog/sfrs_pkg.sv ***
/*
 * Constants for the supply fault reset sequencer host controller.
 * Assumes a 40 MHz mclk and an Avalon-MM slave at 32-bit data.
 */
// Contract
// - The controller enters hold mode by driving the hold pin low.
// - Hold mode ends only when the hold pin stays high for at least 3 us while no fault is seen.
// - A 10k pull-down is fitted from the hold pin to ground.
// - The controller never drives manual_reset_in high; it only pulls low or lets go.
package sfrs_pkg;
	// Clock and hold release timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned HOLD_REL_NS = 3000;
	localparam int unsigned HOLD_REL_CYC =
		(HOLD_REL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_PULSE = 4'h8;
	localparam logic [3:0] OFS_LAT = 4'hC;

	// Control bits
	localparam int CTRL_HOLD = 0;
	localparam int CTRL_MRST = 1;
	localparam int CTRL_REL = 2;

	// Status bits
	localparam int STAT_RST = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_EDGE = 2;
	localparam int STAT_DONE = 3;

	localparam logic [15:0] PULSE_RST = 16'(HOLD_REL_CYC);
	localparam logic [31:0] LAT_MAX = 32'hFFFFFFFF;

	typedef enum logic [1:0] {
		SFRS_IDLE,
		SFRS_PULSE,
		SFRS_WAIT
	} sfrs_state_t;
endpackage

// *** verilog/sfrs_sync.sv ***
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the pin is asynchronous to mclk; ce freezes all state.
 */
`timescale 1ns/1ps
`default_nettype none
module sfrs_sync
#(
	parameter logic RST_VAL = 1'b0
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic pin_in,
	output logic level
);
	logic s1_ff, s2_ff, s3_ff, lvl_ff;
	logic nxt_lvl;

	// Stage one feeds only stage two, so no logic sees a metastable bit
	always_comb
	begin
		nxt_lvl = lvl_ff;
		if (s2_ff == s3_ff)
			nxt_lvl = s2_ff;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			lvl_ff <= RST_VAL;
		end
		else if (ce)
		begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	assign level = lvl_ff;
endmodule
`default_nettype wire

// *** verilog/sfrs_host.sv ***
/*
 * Host controller for a supply supervisor: drives the hold pin and the
 * manual reset pin, watches the supervisor reset, and reports over
 * Avalon-MM. Assumes a pull-down on the hold pin and a supervisor reset
 * output whose polarity is set by RST_ACT_HIGH.
 */
`timescale 1ns/1ps
`default_nettype none
module sfrs_host
#(
	parameter logic RST_ACT_HIGH = 1'b0,
	parameter int unsigned REL_MIN = sfrs_pkg::HOLD_REL_CYC
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sup_reset_in,
	input wire logic hold_pin_in,
	output logic hold_pin_out,
	output logic hold_pin_oe,
	output logic manual_reset_out,
	output logic manual_reset_oe
);
	localparam logic [15:0] REL_MIN16 = 16'(REL_MIN);

	logic rst_lvl, hold_lvl, rst_act, rst_act_d_ff;
	logic hold_arm_ff, nxt_hold_arm;
	logic mrst_ff, nxt_mrst;
	logic [15:0] pulse_len_ff, nxt_pulse_len;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [31:0] lat_ff, nxt_lat;
	logic edge_ff, nxt_edge;
	logic done_ff, nxt_done;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic oe_ff;
	sfrs_pkg::sfrs_state_t st_ff, nxt_st;
	logic wr_go, rd_go, rel_req;

	// Supervisor reset and hold pin, both foreign to mclk
	sfrs_sync #(.RST_VAL(1'b0)) u_rst_sync
	(
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.pin_in(sup_reset_in),
		.level(rst_lvl)
	);

	sfrs_sync #(.RST_VAL(1'b0)) u_hold_sync
	(
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.pin_in(hold_pin_in),
		.level(hold_lvl)
	);

	// Polarity normalised once, so the rest sees active-high reset
	assign rst_act = RST_ACT_HIGH ? rst_lvl : ~rst_lvl;

	// Register address decode shared by read and write paths
	function automatic logic is_ofs(input logic [3:0] a,
		input logic [3:0] o);
		is_ofs = (a == o);
	endfunction

	// Single-cycle wait while ce is high, then the access completes
	assign wr_go = ce & avs_write & ~ack_ff;
	assign rd_go = ce & avs_read & ~ack_ff;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign rel_req = wr_go & is_ofs(avs_address, sfrs_pkg::OFS_CTRL)
		& avs_writedata[sfrs_pkg::CTRL_REL];

	// Control registers and the release sequence
	always_comb
	begin
		nxt_hold_arm = hold_arm_ff;
		nxt_mrst = mrst_ff;
		nxt_pulse_len = pulse_len_ff;
		nxt_cnt = cnt_ff;
		nxt_lat = lat_ff;
		nxt_st = st_ff;
		nxt_edge = edge_ff;
		nxt_done = done_ff;
		nxt_ack = wr_go | rd_go;
		if (wr_go && is_ofs(avs_address, sfrs_pkg::OFS_CTRL))
		begin
			nxt_hold_arm = avs_writedata[sfrs_pkg::CTRL_HOLD];
			nxt_mrst = avs_writedata[sfrs_pkg::CTRL_MRST];
		end
		// Short pulses would not end hold mode, so clamp up
		if (wr_go && is_ofs(avs_address, sfrs_pkg::OFS_PULSE))
		begin
			if (avs_writedata[15:0] < REL_MIN16)
				nxt_pulse_len = REL_MIN16;
			else
				nxt_pulse_len = avs_writedata[15:0];
		end
		// Sticky flags: write one clears, a new event wins
		if (wr_go && is_ofs(avs_address, sfrs_pkg::OFS_STAT))
		begin
			if (avs_writedata[sfrs_pkg::STAT_EDGE])
				nxt_edge = 1'b0;
			if (avs_writedata[sfrs_pkg::STAT_DONE])
				nxt_done = 1'b0;
		end
		if (rst_act != rst_act_d_ff)
			nxt_edge = 1'b1;
		case (st_ff)
			sfrs_pkg::SFRS_IDLE:
			begin
				if (rel_req)
				begin
					nxt_st = sfrs_pkg::SFRS_PULSE;
					nxt_cnt = '0;
					nxt_lat = '0;
					nxt_hold_arm = 1'b0;
				end
			end
			// Hold pin high long enough to leave hold mode
			sfrs_pkg::SFRS_PULSE:
			begin
				nxt_hold_arm = 1'b0;
				if (cnt_ff + 16'h0001 >= pulse_len_ff)
				begin
					nxt_st = sfrs_pkg::SFRS_WAIT;
					if (rst_act)
						nxt_lat = 32'(cnt_ff) + 32'h00000001;
				end
				else
					nxt_cnt = cnt_ff + 16'h0001;
				// Release seen inside the pulse: a later drop overwrites an earlier one
				if (~rst_act && rst_act_d_ff)
					nxt_lat = 32'(cnt_ff);
			end
			// Time from the hold rising edge to reset release
			sfrs_pkg::SFRS_WAIT:
			begin
				if (~rst_act)
				begin
					nxt_st = sfrs_pkg::SFRS_IDLE;
					nxt_done = 1'b1;
				end
				else if (lat_ff != sfrs_pkg::LAT_MAX)
					nxt_lat = lat_ff + 32'h00000001;
				// Software may abort by re-arming hold
				if (nxt_hold_arm)
					nxt_st = sfrs_pkg::SFRS_IDLE;
			end
			default:
				nxt_st = sfrs_pkg::SFRS_IDLE;
		endcase
	end

	// Read data registered so the answer is a flip-flop
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (rd_go)
		begin
			nxt_rdata = '0;
			if (is_ofs(avs_address, sfrs_pkg::OFS_CTRL))
			begin
				nxt_rdata[sfrs_pkg::CTRL_HOLD] = hold_arm_ff;
				nxt_rdata[sfrs_pkg::CTRL_MRST] = mrst_ff;
			end
			else if (is_ofs(avs_address, sfrs_pkg::OFS_STAT))
			begin
				nxt_rdata[sfrs_pkg::STAT_RST] = rst_act;
				nxt_rdata[sfrs_pkg::STAT_BUSY] =
					(st_ff != sfrs_pkg::SFRS_IDLE);
				nxt_rdata[sfrs_pkg::STAT_EDGE] = edge_ff;
				nxt_rdata[sfrs_pkg::STAT_DONE] = done_ff;
			end
			else if (is_ofs(avs_address, sfrs_pkg::OFS_PULSE))
				nxt_rdata[15:0] = pulse_len_ff;
			else if (is_ofs(avs_address, sfrs_pkg::OFS_LAT))
				nxt_rdata = lat_ff;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			hold_arm_ff <= 1'b0;
			mrst_ff <= 1'b0;
			pulse_len_ff <= sfrs_pkg::PULSE_RST;
			cnt_ff <= '0;
			lat_ff <= '0;
			st_ff <= sfrs_pkg::SFRS_IDLE;
			edge_ff <= 1'b0;
			done_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdata_ff <= '0;
			rst_act_d_ff <= ~RST_ACT_HIGH; // Idle reading, no false edge
			oe_ff <= 1'b0;
		end
		else if (ce)
		begin
			hold_arm_ff <= nxt_hold_arm;
			mrst_ff <= nxt_mrst;
			pulse_len_ff <= nxt_pulse_len;
			cnt_ff <= nxt_cnt;
			lat_ff <= nxt_lat;
			st_ff <= nxt_st;
			edge_ff <= nxt_edge;
			done_ff <= nxt_done;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			rst_act_d_ff <= rst_act;
			oe_ff <= 1'b1;
		end
	end

	assign avs_readdata = rdata_ff;

	// Hold pin: low while armed, high otherwise; driven once out of reset
	assign hold_pin_out = ~hold_arm_ff;
	assign hold_pin_oe = oe_ff; // pull-down holds it low until then

	// Manual reset is open-drain: only ever pulls low
	assign manual_reset_out = 1'b0;
	assign manual_reset_oe = mrst_ff;

	// Helper: length of the current high stretch on the hold pin;
	// saturates at 16'hFFFF; a_rel_len adds one in 16 bits, so a long idle high wraps to zero there and fails
	logic [15:0] hi_run_ff, nxt_hi_run;
	always_comb
	begin
		nxt_hi_run = '0;
		if (hold_pin_out)
		begin
			if (hi_run_ff == 16'hFFFF)
				nxt_hi_run = hi_run_ff;
			else
				nxt_hi_run = hi_run_ff + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			hi_run_ff <= '0;
		else if (ce)
			hi_run_ff <= nxt_hi_run;
	end

	property p_hold_low_armed;
		@(posedge mclk) disable iff (!resetn)
		hold_arm_ff |-> (hold_pin_oe && !hold_pin_out);
	endproperty
	a_hold_low_armed: assert property (p_hold_low_armed)
		else $error("hold pin not low while armed");

	property p_rel_len;
		@(posedge mclk) disable iff (!resetn)
		(ce && st_ff == sfrs_pkg::SFRS_PULSE
			&& nxt_st == sfrs_pkg::SFRS_WAIT)
			|-> (hi_run_ff + 16'h0001 >= REL_MIN16);
	endproperty
	a_rel_len: assert property (p_rel_len)
		else $error("release pulse shorter than minimum");

	property p_pulse_high;
		@(posedge mclk) disable iff (!resetn)
		(st_ff == sfrs_pkg::SFRS_PULSE) |-> hold_pin_out;
	endproperty
	a_pulse_high: assert property (p_pulse_high)
		else $error("hold pin dropped during release");

	property p_min_clamp;
		@(posedge mclk) disable iff (!resetn)
		pulse_len_ff >= REL_MIN16;
	endproperty
	a_min_clamp: assert property (p_min_clamp)
		else $error("pulse length below minimum");

	property p_mr_never_high;
		@(posedge mclk) disable iff (!resetn)
		manual_reset_oe |-> !manual_reset_out;
	endproperty
	a_mr_never_high: assert property (p_mr_never_high)
		else $error("manual reset driven high");

	property p_rel_starts;
		@(posedge mclk) disable iff (!resetn)
		(rel_req && st_ff == sfrs_pkg::SFRS_IDLE)
			|=> (st_ff == sfrs_pkg::SFRS_PULSE) ##1 hold_pin_out;
	endproperty
	a_rel_starts: assert property (p_rel_starts)
		else $error("release request not started");

	property p_wait_ack;
		@(posedge mclk) disable iff (!resetn)
		(ce && (avs_read || avs_write) && avs_waitrequest)
			|=> !avs_waitrequest;
	endproperty
	a_wait_ack: assert property (p_wait_ack)
		else $error("access not answered in one cycle");

	c_release: cover property (@(posedge mclk) disable iff (!resetn)
		st_ff == sfrs_pkg::SFRS_WAIT ##1 st_ff == sfrs_pkg::SFRS_IDLE);
	c_mrst: cover property (@(posedge mclk) disable iff (!resetn)
		manual_reset_oe ##[1:20] rst_act);
	c_arm: cover property (@(posedge mclk) disable iff (!resetn)
		$rose(hold_arm_ff));
	c_hold_seen: cover property (@(posedge mclk) disable iff (!resetn)
		$fell(hold_lvl));
endmodule
`default_nettype wire

// *** dv/sfrs_sup_model.sv ***
/*
 * Clocked model of a hold-capable supervisor, active-low reset output.
 * Assumes the bench resolves pin levels and drives fault on mclk edges.
 */
`timescale 1ns/1ps
`default_nettype none
module sfrs_sup_model
#(
	parameter int RST_DLY = 200,
	parameter int HOLD_MIN = 120
)
(
	input wire logic mclk,
	input wire logic fault,
	input wire logic hold_lvl,
	input wire logic manual_lvl,
	output logic rst_n
);
	logic lat = 1'b1;
	int hi_cnt = 0;
	int ok_cnt = 0;
	// Hold latch and release delay; no sense delay in this variant
	always @(posedge mclk)
	begin
		hi_cnt <= hold_lvl ? hi_cnt + 1 : 0;
		if (!hold_lvl)
			lat <= 1'b1;
		else if (hi_cnt >= HOLD_MIN - 1 && !fault)
			lat <= 1'b0;
		// Delay counted from the rising hold edge, fault clearing or manual reset release
		ok_cnt <= (fault || !manual_lvl || !hold_lvl) ? 0
			: ok_cnt + 1;
		rst_n <= !(lat || ok_cnt < RST_DLY);
	end
endmodule
`default_nettype wire

// *** dv/supply_fault_reset_sequencer_bench.sv ***
/*
 * Self-checking bench for the host controller with a supervisor model.
 * Assumes an active-low supervisor reset; pulse length is the last random value written, clamped up to the minimum.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module supply_fault_reset_sequencer_bench;
	localparam int RDLY = 200;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sup_rst_n, hold_out, hold_oe, man_out, man_oe;
	logic ce = 1'b1;
	logic fault = 1'b0;
	logic [31:0] q;
	logic [31:0] d;
	int mismatches = 0;
	int n_compared = 0;
	// Pull-down on the hold pin, manual reset floats high
	wire logic hold_lvl = hold_oe ? hold_out : 1'b0;
	wire logic manual_lvl = man_oe ? man_out : 1'b1;
	sfrs_host dut (.mclk(mclk), .resetn(resetn), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sup_reset_in(sup_rst_n), .hold_pin_in(hold_lvl),
		.hold_pin_out(hold_out), .hold_pin_oe(hold_oe),
		.manual_reset_out(man_out), .manual_reset_oe(man_oe));
	sfrs_sup_model #(.RST_DLY(RDLY)) sup (.mclk(mclk), .fault(fault),
		.hold_lvl(hold_lvl), .manual_lvl(manual_lvl), .rst_n(sup_rst_n));
	initial
	begin
		forever #12.5 mclk = ~mclk;
	end
	// One Avalon transfer, held until waitrequest is seen low
	task av(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task poll(input int idx);
		repeat (500)
		begin
			av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
			if (q[idx] === 1'b1)
				break;
		end
		// A flag that never comes is a failure, not a silent pass
		if (q[idx] !== 1'b1)
			mismatches++;
	endtask
	// Expected pulse length: writes below the minimum clamp up
	function automatic logic [15:0] exp_pulse(input logic [31:0] v);
		if (v[15:0] < 16'(sfrs_pkg::HOLD_REL_CYC))
			exp_pulse = 16'(sfrs_pkg::HOLD_REL_CYC);
		else
			exp_pulse = v[15:0];
	endfunction
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		q = $urandom(99);
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		av(1'b0, sfrs_pkg::OFS_CTRL, 32'h0);
		`CHK(q, 32'h0)
		// Only reset is seen just after reset: no false edge flag
		av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
		`CHK(q, 32'h1)
		// Access stalls while ce is low, then completes
		ce <= 1'b0;
		fork
			av(1'b0, sfrs_pkg::OFS_PULSE, 32'h0);
			begin
				repeat (4) @(posedge mclk);
				`CHK(avs_waitrequest, 1'b1)
				ce <= 1'b1;
			end
		join
		`CHK(q[15:0], sfrs_pkg::PULSE_RST)
		av(1'b0, 4'h1, 32'h0);
		`CHK(q, 32'h0)
		// Pulse lengths: one just under the minimum, then random ones
		d = 32'h00000077;
		repeat (4)
		begin
			av(1'b1, sfrs_pkg::OFS_PULSE, d);
			av(1'b0, sfrs_pkg::OFS_PULSE, 32'h0);
			`CHK(q[15:0], exp_pulse(d))
			d = $urandom_range(0, 400);
		end
		av(1'b1, sfrs_pkg::OFS_CTRL, 32'h1);
		repeat (3) @(posedge mclk);
		`CHK({hold_oe, hold_out}, 2'b10)
		// Random fault bursts while latched
		repeat (3)
		begin
			fault <= 1'b1;
			repeat ($urandom_range(1, 20)) @(posedge mclk);
			fault <= 1'b0;
			repeat ($urandom_range(5, 30)) @(posedge mclk);
		end
		repeat (300) @(posedge mclk);
		av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
		`CHK(q[sfrs_pkg::STAT_RST], 1'b1)
		// Release attempt under fault must not unlatch
		fault <= 1'b1;
		av(1'b1, sfrs_pkg::OFS_CTRL, 32'h4);
		repeat (300) @(posedge mclk);
		av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
		`CHK(q[sfrs_pkg::STAT_RST], 1'b1)
		fault <= 1'b0;
		repeat (300) @(posedge mclk);
		// Clean release: delay counted from the rising hold edge
		av(1'b1, sfrs_pkg::OFS_CTRL, 32'h1);
		repeat (20) @(posedge mclk);
		av(1'b1, sfrs_pkg::OFS_STAT, 32'hC);
		av(1'b1, sfrs_pkg::OFS_CTRL, 32'h4);
		av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
		`CHK(q[sfrs_pkg::STAT_BUSY], 1'b1)
		`CHK(q[sfrs_pkg::STAT_DONE], 1'b0)
		poll(sfrs_pkg::STAT_DONE);
		`CHK(q[sfrs_pkg::STAT_RST], 1'b0)
		`CHK(q[sfrs_pkg::STAT_EDGE], 1'b1)
		`CHK(q[sfrs_pkg::STAT_BUSY], 1'b0)
		av(1'b0, sfrs_pkg::OFS_LAT, 32'h0);
		`CHK(q >= RDLY && q <= RDLY + 6, 1'b1)
		av(1'b0, sfrs_pkg::OFS_CTRL, 32'h0);
		`CHK(q[2:0], 3'h0)
		// Manual reset pulled low only, never driven high
		av(1'b1, sfrs_pkg::OFS_CTRL, 32'h2);
		repeat (2) @(posedge mclk);
		`CHK({man_oe, man_out}, 2'b10)
		repeat (10) @(posedge mclk);
		av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
		`CHK(q[sfrs_pkg::STAT_RST], 1'b1)
		av(1'b1, sfrs_pkg::OFS_CTRL, 32'h0);
		repeat (150) @(posedge mclk);
		av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
		`CHK(q[sfrs_pkg::STAT_RST], 1'b1)
		repeat (80) @(posedge mclk);
		av(1'b0, sfrs_pkg::OFS_STAT, 32'h0);
		`CHK(q[sfrs_pkg::STAT_RST], 1'b0)
		summarize();
	end
	// Watchdog well beyond the expected few thousand cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
